/* File: mfeb_pkg.sv */
// constants and carrier types for the feature-control register bank
package mfeb_pkg;

  // register addresses on the plain register port
  localparam logic [11:0] FEAT_CTRL_ADDR = 12'h100;  // feature-control register
  localparam logic [11:0] PLAT_NEEDS_ADDR = 12'h1a1; // platform-requirements report

  // field positions in the feature-control register
  localparam int BIT_WAIT_SM   = 18;
  localparam int BIT_PF_DIS    = 19;
  localparam int BIT_LEAF_LIM  = 22;
  localparam int BIT_TPR_DIS   = 23;
  localparam int BIT_CACHE_MOD = 24;
  localparam int BIT_NO_EXEC   = 34;

  // field position in the platform-requirements report
  localparam int BIT_PLAT_NEEDS = 18;

  // reset values of every control field
  localparam logic RST_WAIT_SM   = 1'b0;
  localparam logic RST_PF_DIS    = 1'b0;
  localparam logic RST_LEAF_LIM  = 1'b0;
  localparam logic RST_TPR_DIS   = 1'b0;
  localparam logic RST_CACHE_MOD = 1'b0;  // adaptive mode
  localparam logic RST_NO_EXEC   = 1'b0;

  // identification leaf reported while the limit is on
  localparam logic [7:0] LEAF_LIMITED = 8'h03;

  // sector and line geometry for fetches after a miss
  localparam int SECTOR_BYTES = 128;
  localparam int LINE_BYTES   = 64;
  localparam int LINE_OFS_W   = $clog2(LINE_BYTES);
  localparam int SECTOR_OFS_W = $clog2(SECTOR_BYTES);
  localparam int LINES_PER_SEC = SECTOR_BYTES / LINE_BYTES;

  // one register-port access
  typedef struct packed {
    logic [11:0] addr;
    logic [63:0] wdata;
    logic        wr;
    logic        rd;
  } mfeb_req_type;

  // shared control fields of the feature-control register
  typedef struct packed {
    logic wait_sm;
    logic pf_dis;
    logic leaf_lim;
    logic tpr_dis;
    logic cache_mode;
  } mfeb_shared_type;

endpackage

/* File: mfeb_line_pick.sv */
// picks the lines of a 128-byte sector to fetch after a cache miss
`timescale 1ns/100ps
module mfeb_line_pick #(
  parameter int ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0]                      i_miss_addr,
  input  wire logic                                   i_adj_disable,
  output logic      [ADDR_W-1:0]                      o_sector_base,
  output logic      [mfeb_pkg::LINES_PER_SEC-1:0]     o_line_mask
);

  // index of the line holding the missed byte inside its sector
  wire logic line_idx;

  assign line_idx = i_miss_addr[mfeb_pkg::LINE_OFS_W];

  // sector-aligned base: lines are named by mask bit, not by address
  assign o_sector_base = {i_miss_addr[ADDR_W-1:mfeb_pkg::SECTOR_OFS_W],
                          {mfeb_pkg::SECTOR_OFS_W{1'b0}}};

  // disabled: only the needed line; enabled: both lines of the sector
  assign o_line_mask = i_adj_disable ? (line_idx ? 2'h2 : 2'h1)
                                     : 2'h3;

endmodule

/* File: mfeb_top.sv */
// feature-control and platform-requirements register bank with its control outputs
`timescale 1ns/100ps
module mfeb_top #(
  parameter int         LP_COUNT      = 2,
  parameter int         LP_W          = 1,
  parameter int         ADDR_W        = 32,
  parameter int         PTB_W         = 32,
  parameter logic [7:0] MAX_LEAF      = 8'h05,
  parameter bit         SMT_SUPPORTED = 1'b1
) (
  input  wire logic                            I_CLK,
  input  wire logic                            I_RSTN,
  // register port
  input  wire logic [11:0]                     I_ADDR,
  input  wire logic [63:0]                     I_WDATA,
  input  wire logic                            I_WR,
  input  wire logic                            I_RD,
  input  wire logic [LP_W-1:0]                 I_LP_SEL,
  output logic      [63:0]                     O_RDATA,
  output logic                                 O_ACCESS_FAULT,
  // identification and platform inputs
  input  wire logic                            I_CTX_ID_FLAG,
  input  wire logic                            I_PLATFORM_NEEDS,
  // miss requests from the cache
  input  wire logic                            I_MISS_VALID,
  input  wire logic [ADDR_W-1:0]               I_MISS_ADDR,
  output logic                                 O_FETCH_VALID,
  output logic      [ADDR_W-1:0]               O_FETCH_ADDR,
  output logic      [1:0]                      O_FETCH_MASK,
  // page table base of each logical processor
  input  wire logic [LP_COUNT-1:0][PTB_W-1:0]  I_PTB,
  // control outputs
  output logic                                 O_WAIT_SM_ENABLE,
  output logic      [7:0]                      O_LEAF_REPORT,
  output logic                                 O_TPR_MSG_DISABLE,
  output logic                                 O_CACHE_SHARED,
  output logic      [LP_COUNT-1:0]             O_NO_EXEC_DISABLE
);

  // register state
  mfeb_pkg::mfeb_shared_type shared_ctl;
  mfeb_pkg::mfeb_shared_type next_shared_ctl;
  logic [LP_COUNT-1:0]       no_exec;
  logic [LP_COUNT-1:0]       next_no_exec;

  // decode of the current access
  mfeb_pkg::mfeb_req_type req;
  wire logic                 hit_ctrl;
  wire logic                 hit_plat;
  wire logic                 wr_ctrl;
  wire logic                 rd_any;
  wire logic                 fault;
  wire logic                 mode_wr_ok;

  // read views
  wire logic [63:0]          ctrl_view;
  wire logic [63:0]          plat_view;
  wire logic [63:0]          next_rdata;

  // derived control values
  wire logic [7:0]           next_leaf;
  wire logic                 bases_match;
  wire logic                 next_shared_cache;
  wire logic [LP_COUNT-1:0]  ptb_eq;

  // fetch path
  wire logic [ADDR_W-1:0]    pick_base;
  wire logic [1:0]           pick_mask;

  // true when an address names one of the two registers of this bank
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == mfeb_pkg::FEAT_CTRL_ADDR) || (a == mfeb_pkg::PLAT_NEEDS_ADDR);
  endfunction

  // gather the port into one carrier for decoding
  assign req.addr  = I_ADDR;
  assign req.wdata = I_WDATA;
  assign req.wr    = I_WR;
  assign req.rd    = I_RD;

  // address decode
  assign hit_ctrl = (req.addr == mfeb_pkg::FEAT_CTRL_ADDR);
  assign hit_plat = (req.addr == mfeb_pkg::PLAT_NEEDS_ADDR);
  assign wr_ctrl  = req.wr && hit_ctrl;
  assign rd_any   = req.rd;

  // a write to the report or any access off the map is refused
  assign fault = (req.wr && hit_plat)
               || ((req.wr || req.rd) && !is_mapped(req.addr));

  // the mode bit may only change where mode switching exists
  assign mode_wr_ok = I_CTX_ID_FLAG;

  // next value of the shared fields; only named bits are taken from a write
  assign next_shared_ctl.wait_sm    = wr_ctrl ? req.wdata[mfeb_pkg::BIT_WAIT_SM]
                                              : shared_ctl.wait_sm;
  assign next_shared_ctl.pf_dis     = wr_ctrl ? req.wdata[mfeb_pkg::BIT_PF_DIS]
                                              : shared_ctl.pf_dis;
  assign next_shared_ctl.leaf_lim   = wr_ctrl ? req.wdata[mfeb_pkg::BIT_LEAF_LIM]
                                              : shared_ctl.leaf_lim;
  // one copy for the whole package, whichever processor writes it
  assign next_shared_ctl.tpr_dis    = wr_ctrl ? req.wdata[mfeb_pkg::BIT_TPR_DIS]
                                              : shared_ctl.tpr_dis;
  assign next_shared_ctl.cache_mode = (wr_ctrl && mode_wr_ok)
                                      ? req.wdata[mfeb_pkg::BIT_CACHE_MOD]
                                      : shared_ctl.cache_mode;

  // per-processor copy of the no-execute disable, chosen by the selector
  genvar g;
  generate
    for (g = 0; g < LP_COUNT; g++)
    begin : g_lp
      assign next_no_exec[g] = (wr_ctrl && (I_LP_SEL == LP_W'(g)))
                               ? req.wdata[mfeb_pkg::BIT_NO_EXEC]
                               : no_exec[g];
      // every base compared with the first; all equal means shareable
      assign ptb_eq[g] = (I_PTB[g] == I_PTB[0]);
    end
  endgenerate

  assign bases_match = &ptb_eq;

  // read view of the feature-control register; unlisted bits stay zero
  assign ctrl_view = {
    29'h0,                                        // 63:35 reserved
    no_exec[I_LP_SEL],                            // 34
    9'h0,                                         // 33:25 reserved
    shared_ctl.cache_mode,                        // 24
    shared_ctl.tpr_dis,                           // 23
    shared_ctl.leaf_lim,                          // 22
    2'h0,                                         // 21:20 reserved
    shared_ctl.pf_dis,                            // 19
    shared_ctl.wait_sm,                           // 18
    18'h0                                         // lower bits are outside this bank
  };

  // platform report: one live bit, the rest reserved and zero
  assign plat_view = {45'h0, I_PLATFORM_NEEDS, 18'h0};

  // read mux; off-map reads answer zero
  assign next_rdata = !rd_any   ? 64'h0
                    : hit_ctrl  ? ctrl_view
                    : hit_plat  ? plat_view
                    : 64'h0;

  // leaf report follows the limit bit
  assign next_leaf = shared_ctl.leaf_lim ? mfeb_pkg::LEAF_LIMITED : MAX_LEAF;

  // shared mode forces sharing; adaptive shares only on equal bases;
  // without a second thread per core the bit has no effect at all
  assign next_shared_cache = SMT_SUPPORTED
                             && (shared_ctl.cache_mode || bases_match);

  // sector line selection for the fetch after a miss
  mfeb_line_pick #(
    .ADDR_W        (ADDR_W)
  ) mfeb_line_pick_inst (
    .i_miss_addr   (I_MISS_ADDR),
    .i_adj_disable (shared_ctl.pf_dis),
    .o_sector_base (pick_base),
    .o_line_mask   (pick_mask)
  );

  // shared control fields
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      shared_ctl.wait_sm    <= mfeb_pkg::RST_WAIT_SM;
      shared_ctl.pf_dis     <= mfeb_pkg::RST_PF_DIS;
      shared_ctl.leaf_lim   <= mfeb_pkg::RST_LEAF_LIM;
      shared_ctl.tpr_dis    <= mfeb_pkg::RST_TPR_DIS;
      shared_ctl.cache_mode <= mfeb_pkg::RST_CACHE_MOD;
    end
    else
    begin
      shared_ctl <= next_shared_ctl;
    end
  end

  // per-processor no-execute disable
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      no_exec <= {LP_COUNT{mfeb_pkg::RST_NO_EXEC}};
    end
    else
    begin
      no_exec <= next_no_exec;
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_RDATA        <= 64'h0;
      O_ACCESS_FAULT <= 1'b0;
    end
    else
    begin
      O_RDATA        <= next_rdata;
      O_ACCESS_FAULT <= fault;  // one-cycle pulse
    end
  end

  // fetch request one cycle after the miss; the prefetch mode in force
  // at the miss decides, so a write in the same cycle acts on the next miss
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_FETCH_VALID <= 1'b0;
      O_FETCH_ADDR  <= {ADDR_W{1'b0}};
      O_FETCH_MASK  <= 2'h0;
    end
    else
    begin
      O_FETCH_VALID <= I_MISS_VALID;
      O_FETCH_ADDR  <= I_MISS_VALID ? pick_base : {ADDR_W{1'b0}};
      O_FETCH_MASK  <= I_MISS_VALID ? pick_mask : 2'h0;
    end
  end

  // control outputs, registered so they never glitch into the core
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_WAIT_SM_ENABLE  <= mfeb_pkg::RST_WAIT_SM;
      O_LEAF_REPORT     <= MAX_LEAF;
      O_TPR_MSG_DISABLE <= mfeb_pkg::RST_TPR_DIS;
      O_CACHE_SHARED    <= 1'b0;
      O_NO_EXEC_DISABLE <= {LP_COUNT{mfeb_pkg::RST_NO_EXEC}};
    end
    else
    begin
      O_WAIT_SM_ENABLE  <= shared_ctl.wait_sm;
      O_LEAF_REPORT     <= next_leaf;
      O_TPR_MSG_DISABLE <= shared_ctl.tpr_dis;
      O_CACHE_SHARED    <= next_shared_cache;
      O_NO_EXEC_DISABLE <= no_exec;
    end
  end

endmodule

/* File: mfeb_checker.sv */
// port assertions for the feature-control register bank
`timescale 1ns/100ps
module mfeb_checker #(
  parameter int         ADDR_W        = 32,
  parameter int         PTB_W         = 32,
  parameter int         LP_COUNT      = 2,
  parameter logic [7:0] MAX_LEAF      = 8'h05,
  parameter bit         SMT_SUPPORTED = 1'b1
) (
  input wire logic                           I_CLK,
  input wire logic                           I_RSTN,
  input wire logic [11:0]                    I_ADDR,
  input wire logic [63:0]                    I_WDATA,
  input wire logic                           I_WR,
  input wire logic                           I_RD,
  input wire logic                           I_PLATFORM_NEEDS,
  input wire logic                           I_MISS_VALID,
  input wire logic [ADDR_W-1:0]              I_MISS_ADDR,
  input wire logic [LP_COUNT-1:0][PTB_W-1:0] I_PTB,
  input wire logic [63:0]                    O_RDATA,
  input wire logic                           O_ACCESS_FAULT,
  input wire logic                           O_FETCH_VALID,
  input wire logic [ADDR_W-1:0]              O_FETCH_ADDR,
  input wire logic [1:0]                     O_FETCH_MASK,
  input wire logic [7:0]                     O_LEAF_REPORT,
  input wire logic                           O_TPR_MSG_DISABLE,
  input wire logic                           O_CACHE_SHARED
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // access decodes; outputs follow a write two edges later
  wire feat_wr = I_WR && I_ADDR == mfeb_pkg::FEAT_CTRL_ADDR;
  wire feat_rd = I_RD && I_ADDR == mfeb_pkg::FEAT_CTRL_ADDR;
  wire plat_rd = I_RD && I_ADDR == mfeb_pkg::PLAT_NEEDS_ADDR;
  wire plat_wr = I_WR && I_ADDR == mfeb_pkg::PLAT_NEEDS_ADDR;
  // prefetch disable as software last wrote it; a write and a miss on one edge
  // both see the old value, matching the mask the design picks
  logic pf_shadow;
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      pf_shadow <= mfeb_pkg::RST_PF_DIS;
    else if (feat_wr)
      pf_shadow <= I_WDATA[mfeb_pkg::BIT_PF_DIS];
  end
  a_fetch_one_cycle: assert property (1 |=> O_FETCH_VALID == $past(I_MISS_VALID))
    else $error("fetch valid does not follow miss");
  a_fetch_sector_base: assert property (I_MISS_VALID |=>
    O_FETCH_ADDR == {$past(I_MISS_ADDR[ADDR_W-1:7]), 7'h0}) else $error("fetch base wrong");
  a_single_line_pick: assert property (I_MISS_VALID |=> O_FETCH_MASK ==
    ($past(pf_shadow) ? {$past(I_MISS_ADDR[6]), !$past(I_MISS_ADDR[6])} : 2'h3))
    else $error("line pick");
  a_mask_not_empty: assert property (O_FETCH_VALID |-> O_FETCH_MASK != 2'h0)
    else $error("empty fetch mask");
  a_leaf_limit_follows: assert property (feat_wr |=> ##1 O_LEAF_REPORT ==
    ($past(I_WDATA[22], 2) ? mfeb_pkg::LEAF_LIMITED : MAX_LEAF)) else $error("leaf report");
  a_tpr_disable_follows: assert property (feat_wr |=> ##1
    O_TPR_MSG_DISABLE == $past(I_WDATA[23], 2)) else $error("tpr disable");
  a_ro_write_fault: assert property (plat_wr |=> O_ACCESS_FAULT)
    else $error("no fault on read-only write");
  a_plat_read_value: assert property (plat_rd |=>
    O_RDATA == {45'h0, $past(I_PLATFORM_NEEDS), 18'h0}) else $error("platform report");
  a_feat_reserved_zero: assert property (feat_rd |=>
    (O_RDATA & ~64'h0000_0004_01cc_0000) == 64'h0) else $error("reserved bits set");
  a_equal_bases_share: assert property (I_PTB[0] == I_PTB[1] |=>
    O_CACHE_SHARED == SMT_SUPPORTED) else $error("cache sharing");
endmodule
bind mfeb_top mfeb_checker #(.ADDR_W(ADDR_W), .PTB_W(PTB_W), .LP_COUNT(LP_COUNT),
  .MAX_LEAF(MAX_LEAF), .SMT_SUPPORTED(SMT_SUPPORTED)) mfeb_checker_inst (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .I_PLATFORM_NEEDS(I_PLATFORM_NEEDS), .I_MISS_VALID(I_MISS_VALID),
  .I_MISS_ADDR(I_MISS_ADDR), .I_PTB(I_PTB), .O_RDATA(O_RDATA),
  .O_ACCESS_FAULT(O_ACCESS_FAULT), .O_FETCH_VALID(O_FETCH_VALID),
  .O_FETCH_ADDR(O_FETCH_ADDR), .O_FETCH_MASK(O_FETCH_MASK), .O_LEAF_REPORT(O_LEAF_REPORT),
  .O_TPR_MSG_DISABLE(O_TPR_MSG_DISABLE), .O_CACHE_SHARED(O_CACHE_SHARED));

/* File: mfeb_top_tb_top.sv */
// self-checking testbench for the feature-control register bank
`timescale 1ns/100ps
module mfeb_top_tb_top;
  logic                  I_CLK, I_RSTN, I_WR, I_RD, I_LP_SEL, I_CTX_ID_FLAG;
  logic                  I_PLATFORM_NEEDS, I_MISS_VALID, O_ACCESS_FAULT, O_FETCH_VALID;
  logic                  O_WAIT_SM_ENABLE, O_TPR_MSG_DISABLE, O_CACHE_SHARED;
  logic [11:0]           I_ADDR;
  logic [63:0]           I_WDATA, O_RDATA;
  logic [31:0]           I_MISS_ADDR, O_FETCH_ADDR;
  logic [1:0][31:0]      I_PTB;
  logic [1:0]            O_FETCH_MASK, O_NO_EXEC_DISABLE;
  logic [7:0]            O_LEAF_REPORT;
  int                    n_errors, n_tests;
  localparam logic [11:0] FEAT = mfeb_pkg::FEAT_CTRL_ADDR;
  localparam logic [11:0] PLAT = mfeb_pkg::PLAT_NEEDS_ADDR;
  mfeb_top mfeb_top_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_LP_SEL(I_LP_SEL), .O_RDATA(O_RDATA),
    .O_ACCESS_FAULT(O_ACCESS_FAULT), .I_CTX_ID_FLAG(I_CTX_ID_FLAG),
    .I_PLATFORM_NEEDS(I_PLATFORM_NEEDS), .I_MISS_VALID(I_MISS_VALID),
    .I_MISS_ADDR(I_MISS_ADDR), .O_FETCH_VALID(O_FETCH_VALID), .O_FETCH_ADDR(O_FETCH_ADDR),
    .O_FETCH_MASK(O_FETCH_MASK), .I_PTB(I_PTB), .O_WAIT_SM_ENABLE(O_WAIT_SM_ENABLE),
    .O_LEAF_REPORT(O_LEAF_REPORT), .O_TPR_MSG_DISABLE(O_TPR_MSG_DISABLE),
    .O_CACHE_SHARED(O_CACHE_SHARED), .O_NO_EXEC_DISABLE(O_NO_EXEC_DISABLE));
  // 50 MHz clock
  initial
  begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one register access; a write must leave read data at zero
  task acc(input logic w, input logic [11:0] a, input logic [63:0] d, input logic lp,
           input logic [63:0] e, input logic f);
    @(posedge I_CLK);
    I_WR <= w;
    I_RD <= !w;
    I_ADDR <= a;
    I_WDATA <= d;
    I_LP_SEL <= lp;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    I_RD <= 1'b0;
    #1;
    chk(O_RDATA, e);
    chk(O_ACCESS_FAULT, f);
  endtask
  // one miss; the fetch answer stands only in the next cycle
  task miss(input logic [31:0] a, input logic [31:0] ea, input logic [1:0] em);
    @(posedge I_CLK);
    I_MISS_VALID <= 1'b1;
    I_MISS_ADDR <= a;
    @(posedge I_CLK);
    I_MISS_VALID <= 1'b0;
    #1;
    chk(O_FETCH_VALID, 1'b1);
    chk(O_FETCH_ADDR, ea);
    chk(O_FETCH_MASK, em);
  endtask
  // control outputs lag a write by two edges, so wait them out
  task settle;
    repeat (2) @(posedge I_CLK);
    #1;
  endtask
  task end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog: the tests need fewer than 50 cycles
  initial
  begin
    repeat (3000) @(posedge I_CLK);
    n_errors++;
    end_sim;
  end
  initial
  begin
    {I_RSTN, I_WR, I_RD, I_LP_SEL, I_MISS_VALID} = 5'h0;
    {I_CTX_ID_FLAG, I_PLATFORM_NEEDS} = 2'h3;
    I_ADDR = 12'h0;
    I_WDATA = 64'h0;
    I_MISS_ADDR = 32'h0;
    I_PTB = {32'h0000_2000, 32'h0000_1000};
    repeat (4) @(posedge I_CLK);
    I_RSTN <= 1'b1;
    #1;
    chk(O_LEAF_REPORT, 8'h05);
    acc(1'b0, FEAT, 64'h0, 1'b0, 64'h0, 1'b0);
    acc(1'b1, FEAT, '1, 1'b0, 64'h0, 1'b0);
    settle;
    chk(O_WAIT_SM_ENABLE, 1'b1);
    chk(O_LEAF_REPORT, mfeb_pkg::LEAF_LIMITED);
    chk(O_TPR_MSG_DISABLE, 1'b1);
    chk(O_CACHE_SHARED, 1'b1);
    chk(O_NO_EXEC_DISABLE, 2'h1);
    acc(1'b0, FEAT, 64'h0, 1'b0, 64'h0000_0004_01cc_0000, 1'b0);
    acc(1'b0, FEAT, 64'h0, 1'b1, 64'h0000_0000_01cc_0000, 1'b0);
    miss(32'h0000_11c0, 32'h0000_1180, 2'h2);
    miss(32'h0000_1180, 32'h0000_1180, 2'h1);
    acc(1'b1, FEAT, 64'h0, 1'b0, 64'h0, 1'b0);
    miss(32'h0000_11c0, 32'h0000_1180, 2'h3);
    settle;
    chk(O_CACHE_SHARED, 1'b0);
    chk(O_LEAF_REPORT, 8'h05);
    @(posedge I_CLK);
    I_PTB[1] <= 32'h0000_1000;
    settle;
    chk(O_CACHE_SHARED, 1'b1);
    @(posedge I_CLK);
    I_CTX_ID_FLAG <= 1'b0;
    acc(1'b1, FEAT, 64'h0000_0000_0100_0000, 1'b0, 64'h0, 1'b0);
    acc(1'b0, FEAT, 64'h0, 1'b0, 64'h0, 1'b0);
    acc(1'b0, PLAT, 64'h0, 1'b0, 64'h0000_0000_0004_0000, 1'b0);
    acc(1'b1, PLAT, '1, 1'b0, 64'h0, 1'b1);
    acc(1'b0, PLAT, 64'h0, 1'b1, 64'h0000_0000_0004_0000, 1'b0);
    acc(1'b0, 12'h200, 64'h0, 1'b0, 64'h0, 1'b1);
    @(posedge I_CLK);
    I_PLATFORM_NEEDS <= 1'b0;
    acc(1'b0, PLAT, 64'h0, 1'b0, 64'h0, 1'b0);
    end_sim;
  end
endmodule
